// File: core/module_status_ctrl.sv
// status flags, alert output, soft controls and paged management memory
//
// Summary of operation
// - after init delay clear not-ready, raise alert
// - receive loss sets flag and alert quickly
// - transmit fault sets flag and alert quickly
// - any other condition sets flag and alert
// - mask set stops flag driving alert
// - mask cleared lets flag drive alert again
// - power-down bit enters low power promptly
// - power-down cleared restores full operation
// - receive loss squelches receive output, restores after
// - transmit loss squelches optical output, restores after
// - transmit disable set turns lane off
// - transmit disable cleared turns lane on
// - receive disable set turns output off
// - receive disable cleared turns output on
// - squelch-disable set turns squelch off
// - squelch-disable cleared turns squelch on
// - one address, lower page plus upper pages
// - flags in lower page, upper pages selected
// - flags latch when set, clear on read
// - alert released soon after flag read
// - alert active low, soft copy readable
// - loss flags in byte three by lane
`timescale 1ns/1ps
`default_nettype none

module module_status_ctrl
  import module_status_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYCLES_DEF,
  parameter int unsigned NUM_PAGES = NUM_PAGES_DEF
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // raw lane conditions from pins
  input wire lane_cond_t i_cond,
  // datapath controls
  output logic [3:0] o_tx_out_en,
  output logic [3:0] o_rx_out_en,
  output logic o_low_power,
  output logic o_ready,
  // alert pin
  output logic o_fault_alert_n
);

  // widths of the power-on counter and of the index over all upper pages
  localparam int unsigned CNT_W = $clog2(INIT_CYCLES + 1);
  localparam int unsigned MEM_W = $clog2(NUM_PAGES * PAGE_BYTES);

  // latched flag update; the setting event wins over a clear in the same cycle
  // the same helper serves both flag bytes, the fault byte padded to eight bits
  function automatic logic [7:0] latch_flags(input logic [7:0] cur, input logic [7:0] ev, input logic clr);
    latch_flags = (clr ? BYTE_RST : cur) | ev;
  endfunction

  // one strobe at one full byte address; the whole address is compared so a lower
  // offset can never alias into an upper page
  function automatic logic addr_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = strobe && (addr == ofs);
  endfunction

  // synchronisers for the raw conditions
  // each bit is an independent slow level, so no coherence across bits is needed
  lane_cond_t cond_meta_reg;
  lane_cond_t cond_reg;

  // flags, masks and controls
  // masks and controls reset to zero: everything unmasked, squelch enabled
  lane_pair_t los_flag_reg;
  logic [3:0] txf_flag_reg;
  lane_pair_t los_mask_reg;
  logic [3:0] txf_mask_reg;
  logic [3:0] tx_dis_reg;
  logic [3:0] tx_dis_prev_reg;
  logic [3:0] rx_dis_reg;
  lane_pair_t sq_dis_reg;
  logic power_down_reg;
  logic [3:0] tx_fault_state_reg;
  logic [7:0] page_sel_reg;

  // power-on sequencing
  logic [CNT_W-1:0] init_cnt_reg;
  logic not_ready_reg;
  logic init_alert_reg;

  // upper page storage; no reset, so contents are undefined until software writes them
  logic [7:0] upper_mem [NUM_PAGES * PAGE_BYTES];

  // decode helpers
  // all decode is combinational from the bus, so a strobe acts on the edge it is sampled
  logic is_upper;
  logic page_valid;
  logic ctrl_overlay;
  logic sq_dis_hit;
  logic rx_dis_hit;
  logic [MEM_W-1:0] mem_index;
  logic rd_status;
  logic rd_los;
  logic rd_txf;
  logic alert_any;
  logic [7:0] rd_mux;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cond_meta_reg <= '0;
      cond_reg <= '0;
    end
    else
    begin
      cond_meta_reg <= i_cond;
      cond_reg <= cond_meta_reg;
    end
  end

  // address decode shared by reads and writes
  always_comb
  begin
    is_upper = i_addr[BIT_UPPER];
    page_valid = (page_sel_reg < 8'(NUM_PAGES));
    ctrl_overlay = is_upper && (page_sel_reg == CTRL_PAGE) &&
                   ((i_addr == OFS_SQ_DISABLE) || (i_addr == OFS_RX_DISABLE));
    mem_index = MEM_W'(page_sel_reg) * MEM_W'(PAGE_BYTES) + MEM_W'(i_addr[6:0]);
    // the two control bytes overlaid on the control page live in registers, not in memory
    sq_dis_hit = ctrl_overlay && (i_addr == OFS_SQ_DISABLE);
    rx_dis_hit = ctrl_overlay && (i_addr == OFS_RX_DISABLE);
    // read strobes of the bytes that clear on read
    rd_status = addr_hit(i_rd, i_addr, OFS_STATUS);
    rd_los = addr_hit(i_rd, i_addr, OFS_LOS_FLAGS);
    rd_txf = addr_hit(i_rd, i_addr, OFS_TXF_FLAGS);
  end

  // power-on delay: not-ready holds until the count expires
  // the count runs once per reset; the long default sets a 2000 ms delay and widens the counter
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      init_cnt_reg <= '0;
      not_ready_reg <= 1'b1;
      init_alert_reg <= 1'b0;
    end
    else
    begin
      if (not_ready_reg)
      begin
        if (init_cnt_reg == CNT_W'(INIT_CYCLES - 1))
        begin
          not_ready_reg <= 1'b0;
          init_alert_reg <= 1'b1;
        end
        else
          init_cnt_reg <= init_cnt_reg + 1'b1;
      end
      else if (rd_status)
        init_alert_reg <= 1'b0;
    end
  end

  // latched status flags, cleared by reading their byte
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      los_flag_reg <= '0;
      txf_flag_reg <= LANE_RST;
    end
    else
    begin
      // flags are held off until the module reports ready
      // a read and a new event in one cycle keep the flag set, so no event is lost
      los_flag_reg <= not_ready_reg ? '0 : latch_flags(los_flag_reg, cond_reg.los, rd_los);
      txf_flag_reg <= not_ready_reg ? LANE_RST :
                      4'(latch_flags({4'h0, txf_flag_reg}, {4'h0, cond_reg.tx_fault}, rd_txf));
    end
  end

  // interrupt masks; a masked flag still latches and reads back, it only stops pulling the alert
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      los_mask_reg <= '0;
      txf_mask_reg <= LANE_RST;
    end
    else
    begin
      if (addr_hit(i_wr, i_addr, OFS_LOS_MASK))
        los_mask_reg <= i_wdata;
      if (addr_hit(i_wr, i_addr, OFS_TXF_MASK))
        txf_mask_reg <= i_wdata[3:0];
    end
  end

  // per-lane output disables; the receive byte sits in the control page, high nibble
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tx_dis_reg <= LANE_RST;
      rx_dis_reg <= LANE_RST;
    end
    else
    begin
      if (addr_hit(i_wr, i_addr, OFS_TX_DISABLE))
        tx_dis_reg <= i_wdata[3:0];
      if (i_wr && rx_dis_hit)
        rx_dis_reg <= i_wdata[7:4];
    end
  end

  // squelch disables: transmit lanes in the low nibble, receive lanes in the high one,
  // the reverse of the carrier's order, so the fields are filled one by one
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sq_dis_reg <= '0;
    else if (i_wr && sq_dis_hit)
    begin
      sq_dis_reg.tx <= i_wdata[3:0];
      sq_dis_reg.rx <= i_wdata[7:4];
    end
  end

  // power-down bit and page select; both volatile, a reset returns to full power on page 0
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      power_down_reg <= 1'b0;
      page_sel_reg <= PAGE_RST;
    end
    else
    begin
      if (addr_hit(i_wr, i_addr, OFS_POWER_CTRL))
        power_down_reg <= i_wdata[BIT_POWER_DOWN];
      if (addr_hit(i_wr, i_addr, OFS_PAGE_SEL))
        page_sel_reg <= i_wdata;
    end
  end

  // upper page storage; writes to an absent page are dropped
  always_ff @(posedge i_clk_sys)
  begin
    if (i_wr && is_upper && page_valid && !ctrl_overlay)
      upper_mem[mem_index] <= i_wdata;
  end

  // transmit fault shuts the lane until tx disable toggles with the fault gone
  // a persisting fault re-latches every cycle, so toggling alone cannot clear it
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tx_fault_state_reg <= LANE_RST;
      tx_dis_prev_reg <= LANE_RST;
    end
    else
    begin
      tx_dis_prev_reg <= tx_dis_reg;
      tx_fault_state_reg <= cond_reg.tx_fault |
                            (tx_fault_state_reg & ~(tx_dis_reg ^ tx_dis_prev_reg));
    end
  end

  // alert combines unmasked flags with the ready announcement
  // the ready announcement is not maskable: software drops it by reading the status byte
  assign alert_any = init_alert_reg ||
                     |(los_flag_reg & ~los_mask_reg) ||
                     |(txf_flag_reg & ~txf_mask_reg);

  // alert output is active low and follows the flags one cycle later
  // registering it keeps decode glitches off the pin
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_fault_alert_n <= 1'b1;
    else
      o_fault_alert_n <= !alert_any;
  end

  // datapath enables; squelch only acts while not disabled
  // every enable drops while not ready or powered down, so the module stays dark until it reports ready
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_tx_out_en <= LANE_RST;
      o_rx_out_en <= LANE_RST;
    end
    else
    begin
      o_tx_out_en <= ~tx_dis_reg & ~tx_fault_state_reg &
                     ~(cond_reg.los.tx & ~sq_dis_reg.tx) &
                     {LANES{!power_down_reg && !not_ready_reg}};
      o_rx_out_en <= ~rx_dis_reg &
                     ~(cond_reg.los.rx & ~sq_dis_reg.rx) &
                     {LANES{!power_down_reg && !not_ready_reg}};
    end
  end

  // power level outputs; the module stays in power level 1 until it reports ready,
  // and the two outputs are always complements of each other
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_low_power <= 1'b1;
      o_ready <= 1'b0;
    end
    else
    begin
      o_low_power <= power_down_reg || not_ready_reg;
      o_ready <= !power_down_reg && !not_ready_reg;
    end
  end

  // read multiplexer; unmapped lower bytes read zero
  // reads have no side effect except the clear-on-read bytes handled above
  always_comb
  begin
    rd_mux = BYTE_RST;
    if (is_upper)
    begin
      if (sq_dis_hit)
        rd_mux = {sq_dis_reg.rx, sq_dis_reg.tx};
      else if (rx_dis_hit)
        rd_mux = {rx_dis_reg, 4'h0};
      else if (page_valid)
        rd_mux = upper_mem[mem_index];
    end
    else
    begin
      case (i_addr)
        OFS_STATUS:
        begin
          rd_mux[BIT_NOT_READY] = not_ready_reg;
          rd_mux[BIT_ALERT_COPY] = o_fault_alert_n;
        end
        OFS_LOS_FLAGS: rd_mux = los_flag_reg;
        OFS_TXF_FLAGS: rd_mux = {4'h0, txf_flag_reg};
        OFS_TX_DISABLE: rd_mux = {4'h0, tx_dis_reg};
        OFS_POWER_CTRL: rd_mux[BIT_POWER_DOWN] = power_down_reg;
        OFS_LOS_MASK: rd_mux = los_mask_reg;
        OFS_TXF_MASK: rd_mux = {4'h0, txf_mask_reg};
        OFS_PAGE_SEL: rd_mux = page_sel_reg;
        default: rd_mux = BYTE_RST;
      endcase
    end
  end

  // read data stands in the cycle after the strobe only
  // forcing zero between answers keeps a stale byte from being taken twice
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= BYTE_RST;
    else
      o_rdata <= i_rd ? rd_mux : BYTE_RST;
  end

endmodule

`default_nettype wire

// File: core/module_status_pkg.sv
// constants, field layouts and carrier types for the module status and control bank
package module_status_pkg;

  // clocking and documented power-on bound
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned T_INIT_MS = 2000;
  localparam int unsigned INIT_CYCLES_DEF = T_INIT_MS * (CLK_HZ / 1000);

  // memory geometry
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned NUM_PAGES_DEF = 4;
  localparam int unsigned LANES = 4;

  // lower page byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_LOS_FLAGS = 8'h03;
  localparam logic [7:0] OFS_TXF_FLAGS = 8'h04;
  localparam logic [7:0] OFS_TX_DISABLE = 8'h56;
  localparam logic [7:0] OFS_POWER_CTRL = 8'h5d;
  localparam logic [7:0] OFS_LOS_MASK = 8'h64;
  localparam logic [7:0] OFS_TXF_MASK = 8'h65;
  localparam logic [7:0] OFS_PAGE_SEL = 8'h7f;

  // upper page overlay of the squelch and receiver controls
  localparam logic [7:0] CTRL_PAGE = 8'h03;
  localparam logic [7:0] OFS_SQ_DISABLE = 8'hf0;
  localparam logic [7:0] OFS_RX_DISABLE = 8'hf1;

  // bit positions
  localparam int unsigned BIT_NOT_READY = 0;
  localparam int unsigned BIT_ALERT_COPY = 1;
  localparam int unsigned BIT_POWER_DOWN = 0;
  localparam int unsigned BIT_UPPER = 7;

  // reset values of the soft controls
  localparam logic [3:0] LANE_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // one bit per lane and direction, tx in the high nibble
  typedef struct packed {
    logic [3:0] tx;
    logic [3:0] rx;
  } lane_pair_t;

  // raw conditions arriving from the analog front end
  typedef struct packed {
    lane_pair_t los;
    logic [3:0] tx_fault;
  } lane_cond_t;

endpackage

// File: test/lane_cond_model.sv
// far side front end: lane condition levels, changed on its own slow clock
`timescale 1ns/1ps
`default_nettype none
module lane_cond_model
  import module_status_pkg::*;
(
  // link clock and requested levels
  input wire logic i_clk_link,
  input wire lane_cond_t i_want,
  // levels seen by the block
  output lane_cond_t o_cond
);
  // no phase relation to the system clock, so the block must resynchronise
  always @(posedge i_clk_link) o_cond <= i_want;
endmodule
`default_nettype wire

// File: test/module_status_ctrl_checker.sv
// port assertions for the status and control bank
`timescale 1ns/1ps
`default_nettype none
module module_status_ctrl_checker
  import module_status_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYCLES_DEF,
  parameter int unsigned NUM_PAGES = NUM_PAGES_DEF
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // lanes, controls and alert
  input wire lane_cond_t i_cond,
  input wire logic [3:0] o_tx_out_en,
  input wire logic [3:0] o_rx_out_en,
  input wire logic o_low_power,
  input wire logic o_ready,
  input wire logic o_fault_alert_n
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // page three chosen, then a receive disable for lane 0
  sequence s_page3;
    i_wr && i_addr == OFS_PAGE_SEL && i_wdata == CTRL_PAGE;
  endsequence
  sequence s_rx_off0;
    i_wr && i_addr == OFS_RX_DISABLE && i_wdata[4];
  endsequence
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_rx_squelch_on: assert property ($rose(i_cond.los.rx[0]) |-> ##[1:4] !o_rx_out_en[0])
    else $error("receive lane 0 not squelched");
  a_loss_alert_low: assert property ($rose(i_cond.los.rx[0]) && o_ready |-> ##[1:5] !o_fault_alert_n)
    else $error("alert not raised on receive loss");
  a_fault_lane_off: assert property ($rose(i_cond.tx_fault[1]) |-> ##[1:4] !o_tx_out_en[1])
    else $error("faulty transmit lane still enabled");
  a_ready_full_power: assert property (o_ready |-> !o_low_power)
    else $error("ready while in low power");
  a_power_down_low: assert property (i_wr && i_addr == OFS_POWER_CTRL && i_wdata[0] |-> ##[1:3] o_low_power)
    else $error("power down not entered");
  a_tx_disable_off: assert property (i_wr && i_addr == OFS_TX_DISABLE && i_wdata[0] |-> ##[1:3] !o_tx_out_en[0])
    else $error("transmit lane 0 not disabled");
  a_rx_disable_off: assert property (s_page3 ##2 s_rx_off0 |-> ##[1:3] !o_rx_out_en[0])
    else $error("receive lane 0 not disabled");
endmodule
bind module_status_ctrl module_status_ctrl_checker #(.INIT_CYCLES(INIT_CYCLES), .NUM_PAGES(NUM_PAGES)) chk_u (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_cond(i_cond), .o_tx_out_en(o_tx_out_en), .o_rx_out_en(o_rx_out_en),
  .o_low_power(o_low_power), .o_ready(o_ready), .o_fault_alert_n(o_fault_alert_n));
`default_nettype wire

// File: test/test_module_status_ctrl.sv
// self-checking bench for the status and control bank
`timescale 1ns/1ps
`default_nettype none
module test_module_status_ctrl
  import module_status_pkg::*;
;
  localparam int unsigned INIT_SIM = 20;
  logic i_clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  lane_cond_t want = '0;
  lane_cond_t i_cond;
  logic [3:0] o_tx_out_en;
  logic [3:0] o_rx_out_en;
  logic o_low_power;
  logic o_ready;
  logic o_fault_alert_n;
  int miscompares = 0;
  int num_checks = 0;
  // 50 ns system clock, 400 ns link clock with an odd phase offset
  initial forever #25 i_clk_sys = ~i_clk_sys;
  initial
  begin
    #7;
    forever #200 clk_link = ~clk_link;
  end
  module_status_ctrl #(.INIT_CYCLES(INIT_SIM), .NUM_PAGES(NUM_PAGES_DEF)) dut_u (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_cond(i_cond), .o_tx_out_en(o_tx_out_en), .o_rx_out_en(o_rx_out_en),
    .o_low_power(o_low_power), .o_ready(o_ready), .o_fault_alert_n(o_fault_alert_n));
  lane_cond_model lane_u (.i_clk_link(clk_link), .i_want(want), .o_cond(i_cond));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  // read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial
  begin
    #4000000;
    miscompares++;
    finish_test();
  end
  // main sequence; lane waits of 16 cycles cover the link clock plus sync delay
  initial
  begin
    cyc(10);
    chk({7'h00, o_fault_alert_n}, 8'h01);
    chk({7'h00, o_low_power}, 8'h01);
    @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(OFS_STATUS, 8'h03);
    cyc(INIT_SIM + 4);
    chk({7'h00, o_fault_alert_n}, 8'h00);
    rd(OFS_STATUS, 8'h00);
    cyc(2);
    chk({7'h00, o_fault_alert_n}, 8'h01);
    chk({o_tx_out_en, o_rx_out_en}, 8'hff);
    rd(OFS_PAGE_SEL, PAGE_RST);
    want.los.rx = 4'h1;
    cyc(16);
    chk({7'h00, o_fault_alert_n}, 8'h00);
    chk({4'h0, o_rx_out_en}, 8'h0e);
    want = '0;
    cyc(16);
    chk({4'h0, o_rx_out_en}, 8'h0f);
    rd(OFS_LOS_FLAGS, 8'h01);
    rd(OFS_LOS_FLAGS, 8'h00);
    cyc(2);
    chk({7'h00, o_fault_alert_n}, 8'h01);
    want.los.tx = 4'h8;
    cyc(16);
    chk({4'h0, o_tx_out_en}, 8'h07);
    chk({7'h00, o_fault_alert_n}, 8'h00);
    want = '0;
    cyc(16);
    chk({4'h0, o_tx_out_en}, 8'h0f);
    rd(OFS_LOS_FLAGS, 8'h80);
    // masked fault must not pull the alert, unmasking must
    wr(OFS_TXF_MASK, 8'h02);
    want.tx_fault = 4'h2;
    cyc(16);
    chk({7'h00, o_fault_alert_n}, 8'h01);
    chk({4'h0, o_tx_out_en}, 8'h0d);
    wr(OFS_TXF_MASK, 8'h00);
    cyc(3);
    chk({7'h00, o_fault_alert_n}, 8'h00);
    want = '0;
    cyc(16);
    rd(OFS_TXF_FLAGS, 8'h02);
    cyc(2);
    chk({7'h00, o_fault_alert_n}, 8'h01);
    chk({4'h0, o_tx_out_en}, 8'h0d);
    wr(OFS_TX_DISABLE, 8'h03);
    cyc(4);
    chk({4'h0, o_tx_out_en}, 8'h0c);
    wr(OFS_TX_DISABLE, 8'h00);
    cyc(4);
    chk({4'h0, o_tx_out_en}, 8'h0f);
    wr(OFS_POWER_CTRL, 8'h01);
    cyc(4);
    chk({7'h00, o_low_power}, 8'h01);
    wr(OFS_POWER_CTRL, 8'h00);
    cyc(4);
    chk({7'h00, o_ready}, 8'h01);
    wr(OFS_PAGE_SEL, CTRL_PAGE);
    wr(OFS_RX_DISABLE, 8'h10);
    cyc(4);
    chk({4'h0, o_rx_out_en}, 8'h0e);
    rd(OFS_PAGE_SEL, CTRL_PAGE);
    wr(OFS_RX_DISABLE, 8'h00);
    cyc(4);
    chk({4'h0, o_rx_out_en}, 8'h0f);
    // squelch off on lane 1 keeps its output up through a loss
    wr(OFS_SQ_DISABLE, 8'h20);
    rd(OFS_SQ_DISABLE, 8'h20);
    want.los.rx = 4'h2;
    cyc(16);
    chk({4'h0, o_rx_out_en}, 8'h0f);
    wr(OFS_SQ_DISABLE, 8'h00);
    cyc(4);
    chk({4'h0, o_rx_out_en}, 8'h0d);
    want = '0;
    cyc(16);
    rd(OFS_LOS_FLAGS, 8'h02);
    wr(OFS_LOS_FLAGS, 8'hff);
    rd(OFS_LOS_FLAGS, 8'h00);
    // upper pages keep their own bytes at the same address
    wr(8'h80, 8'h5a);
    wr(OFS_PAGE_SEL, 8'h01);
    wr(8'h80, 8'ha5);
    rd(8'h80, 8'ha5);
    wr(OFS_PAGE_SEL, CTRL_PAGE);
    rd(8'h80, 8'h5a);
    wr(OFS_PAGE_SEL, 8'h07);
    rd(8'h80, 8'h00);
    rd(8'h10, 8'h00);
    // a reset in mid-run returns the soft controls to their defaults
    wr(OFS_TX_DISABLE, 8'h05);
    @(posedge i_clk_sys);
    i_reset_n <= 1'b0;
    cyc(2);
    chk({o_tx_out_en, o_rx_out_en}, 8'h00);
    @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(OFS_PAGE_SEL, PAGE_RST);
    rd(OFS_TX_DISABLE, 8'h00);
    rd(OFS_STATUS, 8'h03);
    finish_test();
  end
endmodule
`default_nettype wire
